/* src/fdcw_edge.sv */
/*
 * Rising-edge detector comparing each new sampled word with the previous one.
 * Assumes sample_in is a one-cycle strobe on the core clock.
 */
`timescale 1ns/100ps
`default_nettype none
module fdcw_edge
	import fdcw_pkg::*;
#(
	parameter int WIDTH = CW_WIDTH
) (
	input wire logic core_clk_in, // Core clock
	input wire logic reset_in, // Sync reset, active high
	input wire logic sample_in, // New word valid
	input wire logic [WIDTH-1:0] word_in, // Sampled word
	output logic [WIDTH-1:0] rise_out // Bits that went 0>1
);
	logic [WIDTH-1:0] prev;
	logic [WIDTH-1:0] next_prev;
	logic [WIDTH-1:0] rise;
	logic [WIDTH-1:0] next_rise;

	always_comb begin
		next_prev = prev;
		next_rise = '0;
		if (sample_in) begin
			next_rise = word_in & ~prev; // [RL22]
			next_prev = word_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			prev <= CW_RESET_VALUE;
			rise <= '0;
		end else begin
			prev <= next_prev;
			rise <= next_rise;
		end
	end

	assign rise_out = rise;
endmodule // fdcw_edge
`default_nettype wire

/* src/fdcw_pkg.sv */
/*
 * Package for the fieldbus drive control word decoder: bit positions,
 * drive states, stop kinds, ramp modes and timing constants.
 * Assumes a 250 MHz core clock and one control-word sample per drive cycle.
 */
package fdcw_pkg;
	// Control word bit positions
	localparam int CW_WIDTH = 16;
	localparam int CW_ON = 0;
	localparam int CW_NO_COAST = 1;
	localparam int CW_NO_QSTOP = 2;
	localparam int CW_START = 3;
	localparam int CW_RAMP_EN = 4;
	localparam int CW_RAMP_UNFREEZE = 5;
	localparam int CW_SETPOINT_EN = 6;
	localparam int CW_FAULT_ACK = 7;
	localparam int CW_JOG1 = 8;
	localparam int CW_JOG2 = 9;
	localparam int CW_FB_ENABLE = 10;
	localparam int CW_WATCHDOG = 11;
	localparam int CW_VIN2 = 12;
	localparam int CW_VIN3 = 13;
	localparam int CW_VIN4 = 14;
	localparam int CW_INTERNAL = 15;

	localparam logic [2:0] CTRL_PLACE_FIELDBUS = 3'h3;
	localparam logic [15:0] CW_RESET_VALUE = 16'h0000;

	// Watchdog timing: nominal period 1 s, recommended rate 2 Hz
	localparam int CLK_FREQ_HZ = 250_000_000;
	localparam int WD_PERIOD_MS = 1000;
	localparam int WD_PERIOD_CYCLES = CLK_FREQ_HZ / 1000 * WD_PERIOD_MS;
	localparam int WD_DELAY_WIDTH = 16;
	localparam int WD_TICK_MS = 1;
	localparam int WD_TICK_CYCLES = CLK_FREQ_HZ / 1000 * WD_TICK_MS;

	typedef enum logic [1:0] {
		FDCW_STOP_NONE,
		FDCW_STOP_RAMP,
		FDCW_STOP_COAST,
		FDCW_STOP_QUICK
	} fdcw_stop_t;

	typedef enum logic [1:0] {
		FDCW_RAMP_FOLLOW,
		FDCW_RAMP_OUT_ZERO,
		FDCW_RAMP_HOLD,
		FDCW_RAMP_IN_ZERO
	} fdcw_ramp_t;

	typedef enum logic [2:0] {
		FDCW_SW_INHIBIT,
		FDCW_READY_SWITCH_ON,
		FDCW_READY_RUN,
		FDCW_RUNNING,
		FDCW_FAULT
	} fdcw_state_t;
endpackage

/* src/fdcw_top.sv */
/*
 * Fieldbus drive control word interpreter: samples the 16-bit command word
 * once per drive cycle and turns it into stop, run, ramp, jog and fault
 * actions, plus a watchdog supervisor on bit 11.
 * Assumes the master writes the word on the core clock with a valid strobe
 * and that the drive supplies zero speed, fault and voltage-removed status.
 */
// Function
// (RL1) Rising on bit 0 leaves switch-on inhibit, goes to ready-to-run.
// (RL2) Bit 0 low: ramp stop, then ready-to-switch-on.
// (RL3) Bit 1 low: coast stop, enter switch-on inhibit.
// (RL4) Bit 2 low: stop by configured quick-stop behaviour.
// (RL5) Bit 3 high starts, low stops with configured stop function.
// (RL6) Bit 4 low forces ramp output zero; outranks bits 5, 6.
// (RL7) Bit 5 low freezes ramp; outranks bit 6, yields to 4.
// (RL8) Bit 6 low forces speed reference zero; lowest priority.
// (RL9) Faults reset only on rising edge of bit 7.
// (RL10) After acknowledge, removed voltage means switch-on inhibit.
// (RL11) Bits 8, 9 jog at own references; jog must be enabled.
// (RL12) Fieldbus jog accepted only with bits 4, 5, 6 all zero.
// (RL13) Jog accepted at zero speed; ramp bits resume after zero speed.
// (RL14) Terminal jog runs without start, needs enable, blocked by start.
// (RL15) Both jog references requested: drive stops.
// (RL16) Bit 10 enables fieldbus control only when place is fieldbus.
// (RL17) Bit 10 cleared while running: coasting stop.
// (RL18) Bit 11 watchdog square wave; stopping raises communication fault.
// (RL19) Bit 15 internal, always reads zero in fast mode.
// (RL20) Watchdog active only when delay setting nonzero.
// (RL21) Echo received bit 11 in status bit 15.
// (RL22) Edges found by comparing new word with previous word.
// (RL23) Word sampled once per drive cycle; one value used per cycle.
`timescale 1ns/100ps
`default_nettype none
module fdcw_top
	import fdcw_pkg::*;
#(
	parameter int WD_TICK = WD_TICK_CYCLES
) (
	input wire logic core_clk_in, // Core clock 250 MHz
	input wire logic reset_in, // Sync reset, active high
	input wire logic [CW_WIDTH-1:0] fieldbus_command_word_in, // Received command word
	input wire logic command_valid_in, // Word valid strobe
	input wire logic control_cycle_in, // Drive control cycle strobe
	input wire logic [2:0] control_place_select_in, // Active control place
	input wire logic [WD_DELAY_WIDTH-1:0] watchdog_delay_setting_in, // Watchdog delay, ms
	input wire logic fast_bus_mode_in, // Fast bus mode
	input wire logic aux_jog_enable_in, // Jog enable from aux word
	input wire logic io_jog_enable_in, // Jog enable digital input
	input wire logic io_jog1_in, // Terminal jog 1
	input wire logic io_jog2_in, // Terminal jog 2
	input wire logic io_start_in, // Start from active non-bus place
	input wire logic zero_speed_in, // Drive at zero speed
	input wire logic fault_in, // Drive fault present
	input wire logic voltage_removed_in, // Fault reaction removed voltage
	input wire fdcw_stop_t quick_stop_cfg_in, // Quick-stop behaviour setting
	input wire fdcw_stop_t stop_func_cfg_in, // Normal stop function setting
	output fdcw_state_t drive_state_out, // Drive state
	output fdcw_stop_t stop_cmd_out, // Active stop kind
	output logic run_cmd_out, // Run request
	output fdcw_ramp_t ramp_mode_out, // Ramp generator mode
	output logic jog1_out, // Run at jog reference 1
	output logic jog2_out, // Run at jog reference 2
	output logic fault_reset_out, // Fault acknowledge pulse
	output logic fb_control_active_out, // Fieldbus control active
	output logic comm_fault_out, // Fieldbus communication fault
	output logic watchdog_echo_out, // Status bit 15 echo
	output logic [3:0] fieldbus_virtual_input_out, // Virtual inputs 1..4
	output logic internal_bit_out // Bit 15 as read
);
	// ------------------------------------------------------------
	// Sampling
	// ------------------------------------------------------------
	logic [CW_WIDTH-1:0] held;
	logic [CW_WIDTH-1:0] next_held;
	logic [CW_WIDTH-1:0] cw;
	logic [CW_WIDTH-1:0] next_cw;
	logic sample;
	logic next_sample;
	logic [CW_WIDTH-1:0] rise;

	always_comb begin
		next_held = command_valid_in ? fieldbus_command_word_in : held;
		next_cw = cw;
		next_sample = 1'b0;
		if (control_cycle_in) begin // [RL23]
			next_cw = held;
			next_sample = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			held <= CW_RESET_VALUE;
			cw <= CW_RESET_VALUE;
			sample <= 1'b0;
		end else begin
			held <= next_held;
			cw <= next_cw;
			sample <= next_sample;
		end
	end

	fdcw_edge #(
		.WIDTH(CW_WIDTH)
	) u_edge (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.sample_in(sample),
		.word_in(cw),
		.rise_out(rise)
	);

	// ------------------------------------------------------------
	// Fieldbus control enable
	// ------------------------------------------------------------
	logic fb_active;
	assign fb_active = cw[CW_FB_ENABLE] && control_place_select_in == CTRL_PLACE_FIELDBUS; // [RL16]

	logic fault_ack;
	assign fault_ack = fb_active && rise[CW_FAULT_ACK]; // [RL9]

	fdcw_watchdog #(
		.TICK_CYCLES(WD_TICK)
	) u_wd (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.sample_in(sample),
		.wd_bit_in(cw[CW_WATCHDOG]),
		.delay_ms_in(watchdog_delay_setting_in),
		.clear_in(fault_ack),
		.fault_out(comm_fault_out)
	);

	// ------------------------------------------------------------
	// Jogging
	// ------------------------------------------------------------
	logic ramp_bits_clear;
	logic fb_jog_req;
	logic io_jog_req;
	logic jog1;
	logic jog2;
	logic next_jog1;
	logic next_jog2;
	logic jog_settle;
	logic next_jog_settle;

	assign ramp_bits_clear = !cw[CW_RAMP_EN] && !cw[CW_RAMP_UNFREEZE] && !cw[CW_SETPOINT_EN];
	assign fb_jog_req = fb_active && aux_jog_enable_in && ramp_bits_clear; // [RL11] [RL12]
	// Blocked by a start command, not by the running state the jog itself causes
	assign io_jog_req = io_jog_enable_in && !io_start_in && !(fb_active && cw[CW_START]); // [RL14]

	always_comb begin
		logic want1;
		logic want2;
		want1 = (fb_jog_req && cw[CW_JOG1]) || (io_jog_req && io_jog1_in);
		want2 = (fb_jog_req && cw[CW_JOG2]) || (io_jog_req && io_jog2_in);
		next_jog1 = jog1;
		next_jog2 = jog2;
		next_jog_settle = jog_settle;
		if (want1 && want2) begin // [RL15]
			next_jog1 = 1'b0;
			next_jog2 = 1'b0;
		end else if (!jog1 && !jog2) begin
			// Fieldbus jog starts only from standstill
			if (zero_speed_in || (io_jog_req && !fb_jog_req)) begin // [RL13]
				next_jog1 = want1;
				next_jog2 = want2;
			end
		end else begin
			next_jog1 = want1;
			next_jog2 = want2;
		end
		if ((jog1 || jog2) && !next_jog1 && !next_jog2)
			next_jog_settle = 1'b1;
		else if (zero_speed_in)
			next_jog_settle = 1'b0; // [RL13]
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			jog1 <= 1'b0;
			jog2 <= 1'b0;
			jog_settle <= 1'b0;
		end else begin
			jog1 <= next_jog1;
			jog2 <= next_jog2;
			jog_settle <= next_jog_settle;
		end
	end

	// ------------------------------------------------------------
	// Drive state machine
	// ------------------------------------------------------------
	fdcw_state_t state;
	fdcw_state_t next_state;
	fdcw_stop_t stop_cmd;
	fdcw_stop_t next_stop_cmd;
	logic fb_was_running;
	logic coast_latch;
	logic next_coast_latch;

	assign fb_was_running = state == FDCW_RUNNING;

	always_comb begin
		next_state = state;
		next_stop_cmd = FDCW_STOP_NONE;
		next_coast_latch = coast_latch;
		if (!fb_active && fb_was_running && !jog1 && !jog2)
			next_coast_latch = 1'b1; // [RL17]
		else if (fb_active)
			next_coast_latch = 1'b0;
		unique case (state)
			FDCW_FAULT: begin
				if (fault_ack && !fault_in) // [RL9]
					next_state = voltage_removed_in ? FDCW_SW_INHIBIT
						: FDCW_READY_SWITCH_ON; // [RL10]
			end
			FDCW_SW_INHIBIT: begin
				if (fb_active && rise[CW_ON] && cw[CW_NO_COAST] && cw[CW_NO_QSTOP])
					next_state = FDCW_READY_RUN; // [RL1]
			end
			FDCW_READY_SWITCH_ON: begin
				if (fb_active && cw[CW_ON])
					next_state = FDCW_READY_RUN;
			end
			FDCW_READY_RUN: begin
				if (fb_active && !cw[CW_ON])
					next_state = FDCW_READY_SWITCH_ON; // [RL2]
				else if ((fb_active && cw[CW_START]) || jog1 || jog2)
					next_state = FDCW_RUNNING; // [RL5]
			end
			FDCW_RUNNING: begin
				if (!jog1 && !jog2 && (!fb_active || !cw[CW_START]))
					next_state = FDCW_READY_RUN;
				if (fb_active && !cw[CW_ON]) begin
					next_state = FDCW_READY_SWITCH_ON; // [RL2]
					next_stop_cmd = FDCW_STOP_RAMP;
				end else if (!(fb_active && cw[CW_START]) && !jog1 && !jog2) begin
					next_stop_cmd = stop_func_cfg_in; // [RL5]
				end
			end
		endcase
		if (fb_active && !cw[CW_NO_QSTOP] && state != FDCW_FAULT) begin
			next_state = FDCW_SW_INHIBIT;
			next_stop_cmd = quick_stop_cfg_in; // [RL4]
		end
		if (((fb_active && !cw[CW_NO_COAST]) || coast_latch) && state != FDCW_FAULT) begin
			next_state = FDCW_SW_INHIBIT;
			next_stop_cmd = FDCW_STOP_COAST; // [RL3] [RL17]
		end
		// The acknowledge clears the watchdog fault on this same edge unless the watchdog delay is still expired, so let it leave
		if (fault_in || (comm_fault_out && !fault_ack))
			next_state = FDCW_FAULT; // [RL18]
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state <= FDCW_SW_INHIBIT;
			stop_cmd <= FDCW_STOP_NONE;
			coast_latch <= 1'b0;
		end else begin
			state <= next_state;
			stop_cmd <= next_stop_cmd;
			coast_latch <= next_coast_latch;
		end
	end

	// ------------------------------------------------------------
	// Ramp generator gating (priority 4 > 5 > 6)
	// ------------------------------------------------------------
	fdcw_ramp_t ramp_mode;
	fdcw_ramp_t next_ramp_mode;

	always_comb begin
		next_ramp_mode = FDCW_RAMP_FOLLOW;
		// Ramp bits are muted while jogging and until standstill after it
		if (!fb_active || jog1 || jog2 || jog_settle)
			next_ramp_mode = FDCW_RAMP_FOLLOW; // [RL13]
		else if (!cw[CW_RAMP_EN])
			next_ramp_mode = FDCW_RAMP_OUT_ZERO; // [RL6]
		else if (!cw[CW_RAMP_UNFREEZE])
			next_ramp_mode = FDCW_RAMP_HOLD; // [RL7]
		else if (!cw[CW_SETPOINT_EN])
			next_ramp_mode = FDCW_RAMP_IN_ZERO; // [RL8]
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in)
			ramp_mode <= FDCW_RAMP_FOLLOW;
		else
			ramp_mode <= next_ramp_mode;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign drive_state_out = state;
	assign stop_cmd_out = stop_cmd;
	assign run_cmd_out = state == FDCW_RUNNING;
	assign ramp_mode_out = ramp_mode;
	assign jog1_out = jog1;
	assign jog2_out = jog2;
	assign fault_reset_out = fault_ack;
	assign fb_control_active_out = fb_active;
	assign watchdog_echo_out = cw[CW_WATCHDOG]; // [RL21]
	assign fieldbus_virtual_input_out = {cw[CW_VIN4], cw[CW_VIN3], cw[CW_VIN2], cw[CW_WATCHDOG]};
	assign internal_bit_out = fast_bus_mode_in ? 1'b0 : cw[CW_INTERNAL]; // [RL19]
endmodule // fdcw_top
`default_nettype wire

/* src/fdcw_watchdog.sv */
/*
 * Watchdog pulse supervisor: faults when the bit stops toggling for the
 * configured delay (in milliseconds). Zero delay disables supervision.
 * Assumes sample_in strobes once per drive cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module fdcw_watchdog
	import fdcw_pkg::*;
#(
	parameter int TICK_CYCLES = WD_TICK_CYCLES
) (
	input wire logic core_clk_in, // Core clock
	input wire logic reset_in, // Sync reset, active high
	input wire logic sample_in, // New word valid
	input wire logic wd_bit_in, // Received watchdog bit
	input wire logic [WD_DELAY_WIDTH-1:0] delay_ms_in, // Watchdog delay setting
	input wire logic clear_in, // Fault acknowledge pulse
	output logic fault_out // Communication fault
);
	logic [31:0] tick_cnt;
	logic [31:0] next_tick_cnt;
	logic [WD_DELAY_WIDTH-1:0] ms_cnt;
	logic [WD_DELAY_WIDTH-1:0] next_ms_cnt;
	logic last_bit;
	logic next_last_bit;
	logic fault;
	logic next_fault;

	always_comb begin
		next_tick_cnt = tick_cnt;
		next_ms_cnt = ms_cnt;
		next_last_bit = last_bit;
		next_fault = fault;
		if (delay_ms_in == '0) begin // [RL20]
			next_tick_cnt = '0;
			next_ms_cnt = '0;
			next_fault = 1'b0;
		end else begin
			if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
				next_tick_cnt = '0;
				if (ms_cnt != delay_ms_in)
					next_ms_cnt = ms_cnt + 1'b1;
			end else begin
				next_tick_cnt = tick_cnt + 32'h0000_0001;
			end
			if (sample_in && wd_bit_in != last_bit) begin
				next_ms_cnt = '0;
				next_tick_cnt = '0;
			end
			if (clear_in)
				next_fault = 1'b0;
			if (ms_cnt == delay_ms_in) // [RL18]
				next_fault = 1'b1;
		end
		if (sample_in)
			next_last_bit = wd_bit_in;
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			tick_cnt <= '0;
			ms_cnt <= '0;
			last_bit <= 1'b0;
			fault <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			ms_cnt <= next_ms_cnt;
			last_bit <= next_last_bit;
			fault <= next_fault;
		end
	end

	assign fault_out = fault;
endmodule // fdcw_watchdog
`default_nettype wire

/* test/fdcw_master_model.sv */
/*
 * Bus master model: sends one command word per request, then the cycle strobe.
 * Assumes requests are spaced well apart by the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module fdcw_master_model (
	input wire logic core_clk_in, // Core clock
	input wire logic reset_in, // Sync reset
	input wire logic go_in, // Send one word
	input wire logic wd_run_in, // Toggle watchdog per word
	input wire logic [15:0] word_in, // Word to send
	output logic [15:0] word_out, // Bus word
	output logic valid_out, // Word valid
	output logic cycle_out // Control cycle strobe
);
	logic wd;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			{wd, valid_out, cycle_out} <= 3'h0;
			word_out <= 16'h0000;
		end else begin
			valid_out <= go_in;
			cycle_out <= valid_out;
			if (go_in) begin
				wd <= wd ^ wd_run_in;
				word_out <= wd_run_in ? {word_in[15:12], !wd, word_in[10:0]} : word_in;
			end else begin
				// Stale bus content must never look valid
				word_out <= ~word_out;
			end
		end
	end
endmodule // fdcw_master_model
`default_nettype wire

/* test/fdcw_top_bench.sv */
/*
 * Self-checking bench for the control word interpreter.
 * Assumes the master model on the bus side and a 250 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module fdcw_top_bench
	import fdcw_pkg::*;
;
	localparam logic [15:0] RUN = 16'h047F;
	localparam logic [15:0] RDY = 16'h0477;
	logic clk, rst, go, wd_run, fast, aux_jog, io_jen, io_j1, io_j2, io_start, zspd, flt, vrem;
	logic [15:0] word, cw, wd_delay;
	logic cw_valid, cw_cycle, run, jog1, jog2, fres, fb_act, comm, echo, intb;
	logic [2:0] place;
	logic [3:0] vin;
	fdcw_stop_t qs_cfg, sf_cfg, stop_cmd;
	fdcw_state_t state;
	fdcw_ramp_t ramp;
	int bad_count, checks_done, pulses, cycles;

	fdcw_master_model i_fdcw_master_model (.core_clk_in(clk), .reset_in(rst), .go_in(go),
		.wd_run_in(wd_run), .word_in(word), .word_out(cw), .valid_out(cw_valid), .cycle_out(cw_cycle));
	// Small tick keeps the millisecond watchdog short
	fdcw_top #(.WD_TICK(4)) i_fdcw_top (.core_clk_in(clk), .reset_in(rst),
		.fieldbus_command_word_in(cw), .command_valid_in(cw_valid), .control_cycle_in(cw_cycle),
		.control_place_select_in(place), .watchdog_delay_setting_in(wd_delay),
		.fast_bus_mode_in(fast), .aux_jog_enable_in(aux_jog), .io_jog_enable_in(io_jen),
		.io_jog1_in(io_j1), .io_jog2_in(io_j2), .io_start_in(io_start), .zero_speed_in(zspd),
		.fault_in(flt), .voltage_removed_in(vrem), .quick_stop_cfg_in(qs_cfg),
		.stop_func_cfg_in(sf_cfg), .drive_state_out(state), .stop_cmd_out(stop_cmd),
		.run_cmd_out(run), .ramp_mode_out(ramp), .jog1_out(jog1), .jog2_out(jog2),
		.fault_reset_out(fres), .fb_control_active_out(fb_act), .comm_fault_out(comm),
		.watchdog_echo_out(echo), .fieldbus_virtual_input_out(vin), .internal_bit_out(intb));

	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (fres === 1'b1) pulses++;
		if (cycles == 6000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One word per control cycle; state settles three edges after the strobe
	task automatic send(input logic [15:0] w);
		@(posedge clk);
		#1 word = w;
		go = 1;
		idle(1);
		go = 0;
		idle(8);
	endtask
	function automatic fdcw_ramp_t exp_ramp(input logic [2:0] b);
		if (!b[0]) return FDCW_RAMP_OUT_ZERO;
		if (!b[1]) return FDCW_RAMP_HOLD;
		if (!b[2]) return FDCW_RAMP_IN_ZERO;
		return FDCW_RAMP_FOLLOW;
	endfunction

	initial begin
		{rst, go, wd_run, fast, aux_jog, io_jen, io_j1, io_j2, io_start, flt, vrem} = '1;
		{go, wd_run, fast, aux_jog, io_jen, io_j1, io_j2, io_start, flt, vrem} = '0;
		{word, wd_delay, bad_count, checks_done, pulses, cycles} = '0;
		place = 3'h3;
		zspd = 1;
		qs_cfg = FDCW_STOP_QUICK;
		sf_cfg = FDCW_STOP_RAMP;
		idle(4);
		rst = 0;
		`CHK(state, FDCW_SW_INHIBIT)
		send(16'h0407); `CHK(state, FDCW_READY_RUN)
		`CHK(fb_act, 1'b1)
		send(RUN); `CHK(run, 1'b1)
		for (int i = 0; i < 8; i++) begin
			send(16'h040F | 16'(i << 4)); `CHK(ramp, exp_ramp(3'(i)))
		end
		send(16'h7C7F); `CHK({echo, vin}, 5'h1F)
		send(16'hC47F); `CHK(intb, 1'b1)
		fast = 1;
		idle(2); `CHK(intb, 1'b0)
		fast = 0;
		send(16'h047D); `CHK(state, FDCW_SW_INHIBIT)
		send(16'h0476); send(RDY); `CHK(state, FDCW_READY_RUN)
		send(RUN); send(16'h047B); `CHK(stop_cmd, FDCW_STOP_QUICK)
		send(16'h0476); send(RDY); send(RUN); send(16'h047E); `CHK(state, FDCW_READY_SWITCH_ON)
		send(RDY); send(RUN); send(RDY); `CHK(run, 1'b0)
		for (int v = 0; v < 2; v++) begin
			flt = 1;
			vrem = v[0];
			idle(6); `CHK(state, FDCW_FAULT)
			flt = 0;
			pulses = 0;
			send(RDY); send(16'h04F6); send(16'h04F6); `CHK(pulses, 1)
			`CHK(state, v ? FDCW_SW_INHIBIT : FDCW_READY_SWITCH_ON)
		end
		vrem = 0;
		aux_jog = 1;
		send(16'h0406); send(16'h0407); send(16'h0507); `CHK(jog1, 1'b1)
		send(16'h0577); `CHK(jog1, 1'b0)
		send(16'h0407);
		zspd = 0;
		send(16'h0607); `CHK(jog2, 1'b0)
		zspd = 1;
		send(16'h0707); `CHK({jog1, jog2}, 2'h0)
		aux_jog = 0;
		send(16'h0507); `CHK(jog1, 1'b0)
		send(16'h0407);
		{io_jen, io_j1} = 2'h3;
		idle(6); `CHK(jog1, 1'b1)
		io_start = 1;
		idle(6); `CHK(jog1, 1'b0)
		{io_jen, io_j1, io_start} = 3'h0;
		send(RUN); send(16'h007F); `CHK(stop_cmd, FDCW_STOP_COAST)
		`CHK(fb_act, 1'b0)
		place = 3'h1;
		send(RUN); `CHK(fb_act, 1'b0)
		place = 3'h3;
		wd_delay = 16'h0005;
		wd_run = 1;
		repeat (5) send(RDY);
		`CHK(comm, 1'b0)
		idle(60); `CHK(comm, 1'b1)
		wd_delay = 16'h0000;
		idle(4); `CHK(comm, 1'b0)
		conclude();
	end
endmodule // fdcw_top_bench
`default_nettype wire

/* test/fdcw_top_properties.sv */
/*
 * Port-level checks for the control word interpreter.
 * Assumes a bind to fdcw_top and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module fdcw_top_checker
	import fdcw_pkg::*;
#(
	parameter int WD_TICK = WD_TICK_CYCLES
) (
	input wire logic core_clk_in, // Core clock
	input wire logic reset_in, // Sync reset
	input wire logic [2:0] control_place_select_in, // Control place
	input wire logic [WD_DELAY_WIDTH-1:0] watchdog_delay_setting_in, // Watchdog delay
	input wire logic fast_bus_mode_in, // Fast bus mode
	input wire logic fault_in, // Drive fault
	input wire logic voltage_removed_in, // Voltage removed
	input wire fdcw_state_t drive_state_out, // Drive state
	input wire fdcw_stop_t stop_cmd_out, // Stop kind
	input wire logic run_cmd_out, // Run request
	input wire logic jog1_out, // Jog 1
	input wire logic jog2_out, // Jog 2
	input wire logic fault_reset_out, // Acknowledge pulse
	input wire logic fb_control_active_out, // Fieldbus control
	input wire logic comm_fault_out, // Communication fault
	input wire logic internal_bit_out // Bit 15 as read
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	sequence s_ack(logic removed);
		fault_reset_out && drive_state_out == FDCW_FAULT && !fault_in && voltage_removed_in == removed;
	endsequence
	sequence s_lands(fdcw_state_t st);
		##[1:2] drive_state_out == st;
	endsequence

	property p_internal; fast_bus_mode_in |-> !internal_bit_out; endproperty
	a_internal: assert property (p_internal) else $error("bit 15 shown in fast mode");
	property p_place; fb_control_active_out |-> control_place_select_in == CTRL_PLACE_FIELDBUS; endproperty
	a_place: assert property (p_place) else $error("bus control away from bus place");
	property p_pulse; $rose(fault_reset_out) |=> !fault_reset_out; endproperty
	a_pulse: assert property (p_pulse) else $error("acknowledge pulse too long");
	property p_run; run_cmd_out == (drive_state_out == FDCW_RUNNING); endproperty
	a_run: assert property (p_run) else $error("run request and state disagree");
	property p_jogs; !(jog1_out && jog2_out); endproperty
	a_jogs: assert property (p_jogs) else $error("both jogs active");
	property p_wd_off; (watchdog_delay_setting_in == 0) [*3] |-> !comm_fault_out; endproperty
	a_wd_off: assert property (p_wd_off) else $error("watchdog fault while disabled");
	property p_coast; stop_cmd_out == FDCW_STOP_COAST |-> ##[0:2] drive_state_out == FDCW_SW_INHIBIT;
	endproperty
	a_coast: assert property (p_coast) else $error("coast stop without inhibit");
	property p_ack_kept; s_ack(1'b0) |-> s_lands(FDCW_READY_SWITCH_ON); endproperty
	a_ack_kept: assert property (p_ack_kept) else $error("acknowledge did not recover");
	property p_ack_off; s_ack(1'b1) |-> s_lands(FDCW_SW_INHIBIT); endproperty
	a_ack_off: assert property (p_ack_off) else $error("acknowledge without inhibit");
endmodule // fdcw_top_checker

bind fdcw_top fdcw_top_checker #(.WD_TICK(WD_TICK)) i_fdcw_top_checker (.core_clk_in, .reset_in,
	.control_place_select_in, .watchdog_delay_setting_in, .fast_bus_mode_in, .fault_in,
	.voltage_removed_in, .drive_state_out, .stop_cmd_out, .run_cmd_out, .jog1_out, .jog2_out,
	.fault_reset_out, .fb_control_active_out, .comm_fault_out, .internal_bit_out);
`default_nettype wire
